// file: bench/gpb_pad_model.sv
// Board side of the pins: external drivers, pulls, floating levels.
// Assumes pad outputs change only after rising clock edges.
`timescale 1ns/1ps
`default_nettype none
module gpb_pad_model (
	input wire logic clk_i,
	input wire logic [39:0] out_i,
	input wire logic [39:0] oe_i,
	input wire logic [39:0] pu_i,
	input wire logic [39:0] pd_i,
	input wire logic [39:0] ext_val_i,
	input wire logic [39:0] ext_en_i,
	output logic [39:0] pin_o
);
	logic [39:0] last_q = 40'h0;
	always_ff @(posedge clk_i) last_q <= pin_o;
	// Undriven pins flip each cycle so a stale level never passes for data
	always_comb begin
		for (int i = 0; i < 40; i++) begin
			pin_o[i] = oe_i[i] ? out_i[i] : ext_en_i[i] ? ext_val_i[i] :
				pu_i[i] ? 1'b1 : pd_i[i] ? 1'b0 : ~last_q[i];
		end
	end
endmodule
`default_nettype wire

// file: bench/gpb_port_block_props.sv
// Checker: bus answers, quiet pins, hold freeze, interrupt cause.
// Bound into gpb_port_block; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module gpb_port_block_props
	import gpb_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic [39:0] pad_in_i,
	input wire logic [39:0] pad_out_o,
	input wire logic [39:0] pad_oe_o,
	input wire logic [39:0] pad_pu_o,
	input wire logic [39:0] pad_pd_o,
	input wire logic [39:0] pad_ie_o,
	input wire logic [39:0] fa_in_o,
	input wire logic [39:0] fb_in_o,
	input wire logic [4:0] irq_o
);
	logic hold_q;
	// Mirror of the shared hold bit, which no port shows
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hold_q <= 1'b0;
		end else if (wr_i && addr_i[7:4] < 4'h5 && addr_i[3:0] == OFS_HOLD) begin
			hold_q <= wdata_i[HOLD_BIT];
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_held;
		hold_q ##1 hold_q;
	endsequence
	a_quiet_release: assert property ($rose(rst_b_i) |->
		(pad_oe_o | pad_ie_o) == 40'h0 && irq_o == 5'h0) else $error("pins live at release");
	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data outside its cycle");
	a_unmapped_zero: assert property (rd_i && addr_i[7] |=> rdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_absent_quiet: assert property (((pad_oe_o | pad_ie_o | pad_pu_o | pad_pd_o)
		& ~PIN_PRESENT) == 40'h0) else $error("absent pin active");
	a_one_owner: assert property ((fa_in_o & fb_in_o) == 40'h0
		&& ((fa_in_o | fb_in_o) & ~PIN_PRESENT) == 40'h0) else $error("pin to two owners");
	a_hold_out: assert property (s_held |-> $stable(pad_out_o) && $stable(pad_oe_o))
		else $error("output moved in hold");
	a_hold_cfg: assert property (s_held |-> $stable(pad_ie_o)
		&& $stable(pad_pu_o | pad_pd_o)) else $error("config moved in hold");
	// Input-enable or hold writes reach the edge detector two cycles late
	a_irq_cause: assert property ($rose(|irq_o) |-> $past(wr_i) || $past(wr_i, 2)
		|| $past(wr_i, 3) || $past(pad_in_i) != $past(pad_in_i, 2))
		else $error("request without cause");
endmodule
bind gpb_port_block gpb_port_block_props u_gpb_port_block_props (.core_clk_i, .rst_b_i,
	.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pad_in_i, .pad_out_o, .pad_oe_o, .pad_pu_o,
	.pad_pd_o, .pad_ie_o, .fa_in_o, .fb_in_o, .irq_o);
`default_nettype wire

// file: bench/gpb_port_block_tb_top.sv
// Bench for the pin block: register rows, then drive modes, hold, sources, interrupts, reset.
// Assumes the pad model closes the pin loop; peripheral outputs are driven by the bench.
`timescale 1ns/1ps
`default_nettype none
module gpb_port_block_tb_top
	import gpb_pkg::*;
;
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r;} gpb_row_type;
	gpb_row_type rows [10] = '{'{8'h00, 32'hFF, 32'h07}, '{8'h10, 32'hFF, 32'h1F},
		'{8'h23, 32'hFFFF, 32'h0707}, '{8'h35, 32'hFF, 32'h03}, '{8'h35, 32'h0, 32'h0},
		'{8'h80, 32'hFFFFFFFF, 32'h0}, '{8'h50, 32'hFFFFFFFF, 32'h0}, '{8'h11, 32'hFF, 32'h0},
		'{8'h48, 32'h1, 32'h1}, '{8'h18, 32'h0, 32'h0}};
	logic [2:0] dexp [16] = '{3'b000, 3'b010, 3'b100, 3'b000, 3'b100, 3'b100, 3'b010, 3'b000,
		3'b000, 3'b100, 3'b001, 3'b100, 3'b000, 3'b100, 3'b001, 3'b000};
	logic [4:0] irows [5] = '{{EDGE_RISE, 3'b110}, {EDGE_FALL, 3'b101}, {EDGE_BOTH, 3'b111},
		{EDGE_NONE, 3'b100}, {EDGE_RISE, 3'b000}};
	logic core_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] addr_i = 8'h0;
	logic [31:0] wdata_i = 32'h0;
	logic [39:0] fa_out_i = 40'h0, fa_oe_i = 40'h0, ext_val = 40'h0, ext_en = 40'h0;
	logic [39:0] fb_out_i = 40'h0, fb_oe_i = 40'h0;
	logic [31:0] rdata_o;
	logic [39:0] pad_in_i, pad_out_o, pad_oe_o, pad_pu_o, pad_pd_o, pad_ie_o, fa_in_o, fb_in_o;
	logic [39:0] pad_lvttl_o, pad_slow_o;
	logic [4:0] irq_o;
	int err_total = 0;
	int checked = 0;
	always #20 core_clk_i = ~core_clk_i;
	gpb_port_block u_gpb_port_block (.core_clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .pad_in_i, .pad_out_o, .pad_oe_o, .pad_pu_o, .pad_pd_o, .pad_ie_o,
		.pad_lvttl_o, .pad_slow_o, .fa_out_i, .fa_oe_i, .fb_out_i, .fb_oe_i,
		.fa_in_o, .fb_in_o, .irq_o);
	gpb_pad_model u_gpb_pad_model (.clk_i(core_clk_i), .out_i(pad_out_o), .oe_i(pad_oe_o),
		.pu_i(pad_pu_o), .pd_i(pad_pd_o), .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_o(pad_in_i));
	task automatic close_out;
		$display("mismatches %0d of %0d checks", err_total, checked);
		if (err_total == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1 chk({8'h0, rdata_o}, {8'h0, e});
	endtask
	// Run time is a few hundred cycles; the limit leaves wide margin
	initial begin
		#400000;
		err_total++;
		close_out;
	end
	initial begin
		tick(19);
		chk(pad_oe_o | pad_ie_o | pad_pu_o | {35'h0, irq_o}, 40'h0);
		@(posedge core_clk_i);
		rst_b_i <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, rows[i].r);
		end
		wr(8'h13, 32'h0201_0101);
		wr(8'h10, 32'h1);
		// Every mode code, first with a one and then with a zero on the data bit
		for (int m = 0; m < 16; m++) begin
			if (m == 8) begin
				wr(8'h10, 32'h0);
			end
			wr(8'h12, m % 8);
			tick(2);
			chk({37'h0, pad_oe_o[8], pad_pu_o[8], pad_pd_o[8]}, {37'h0, dexp[m]});
		end
		chk(pad_lvttl_o, 40'h100);
		chk(pad_slow_o, 40'h200);
		wr(8'h10, 32'h1);
		wr(8'h12, {29'h0, DRV_STRONG});
		tick(1);
		rd(8'h11, 32'h1);
		wr(8'h08, 32'h1);
		wr(8'h10, 32'h0);
		tick(3);
		chk(pad_out_o & 40'h100, 40'h100);
		wr(8'h08, 32'h0);
		tick(2);
		chk(pad_out_o & 40'h100, 40'h0);
		@(posedge core_clk_i);
		fa_out_i <= 40'h100;
		fa_oe_i <= 40'h100;
		wr(8'h14, {30'h0, SEL_FIX_A});
		tick(3);
		chk((pad_out_o & pad_oe_o) | fa_in_o | fb_in_o, 40'h100);
		wr(8'h14, {30'h0, SEL_FIX_B});
		tick(3);
		chk(fa_in_o | (pad_oe_o & 40'h100), 40'h0);
		@(posedge core_clk_i);
		fb_out_i <= 40'h100;
		fb_oe_i <= 40'h100;
		tick(3);
		chk((pad_out_o & pad_oe_o) | fa_in_o | fb_in_o, 40'h100);
		wr(8'h14, {30'h0, SEL_GPIO});
		ext_en <= 40'h1_0000;
		wr(8'h23, 32'h1);
		foreach (irows[i]) begin
			wr(8'h26, {30'h0, irows[i][4:3]});
			wr(8'h25, {31'h0, irows[i][2]});
			wr(8'h27, 32'h1);
			ext_val <= 40'h1_0000;
			tick(3);
			chk({35'h0, irq_o}, {37'h0, irows[i][1], 2'b0});
			rd(8'h27, {31'h0, irows[i][1]});
			wr(8'h27, 32'h1);
			ext_val <= 40'h0;
			tick(3);
			chk({35'h0, irq_o}, {37'h0, irows[i][0], 2'b0});
			wr(8'h27, 32'h1);
		end
		@(posedge core_clk_i);
		rst_b_i <= 1'b0;
		tick(1);
		chk(pad_oe_o | pad_ie_o | pad_pu_o | pad_pd_o, 40'h0);
		@(posedge core_clk_i);
		rst_b_i <= 1'b1;
		tick(2);
		chk(pad_oe_o | pad_ie_o, 40'h0);
		close_out;
	end
endmodule
`default_nettype wire

// file: core/gpb_pkg.sv
// Constants, register map and state layout of the general-purpose pin block.
// Assumes one always-running clock; all values here are shared by design and bench.
package gpb_pkg;
	localparam int NPORT = 5;
	localparam int NBIT = 8;
	localparam int NPIN = NPORT * NBIT;
	// Pin positions that exist; 15 pins over five ports
	localparam logic [39:0] PIN_PRESENT = 40'h03_03_07_1F_07;
	// Address: [6:4] port, [3:0] register word
	localparam logic [3:0] OFS_DOUT = 4'h0;
	localparam logic [3:0] OFS_PIN = 4'h1;
	localparam logic [3:0] OFS_DMODE = 4'h2;
	localparam logic [3:0] OFS_BUFCFG = 4'h3;
	localparam logic [3:0] OFS_ALTSEL = 4'h4;
	localparam logic [3:0] OFS_INTEN = 4'h5;
	localparam logic [3:0] OFS_INTEDGE = 4'h6;
	localparam logic [3:0] OFS_INTSTAT = 4'h7;
	localparam logic [3:0] OFS_HOLD = 4'h8;
	// BUFCFG field positions (low bit of each byte field)
	localparam int BUF_IN_EN_LSB = 0;
	localparam int BUF_OUT_EN_LSB = 8;
	localparam int BUF_LVTTL_LSB = 16;
	localparam int BUF_SLOW_LSB = 24;
	localparam int HOLD_BIT = 0;
	// Drive modes
	localparam logic [2:0] DRV_INPUT = 3'h0;
	localparam logic [2:0] DRV_WUP_SDN = 3'h1;
	localparam logic [2:0] DRV_SUP_WDN = 3'h2;
	localparam logic [2:0] DRV_OD_LOW = 3'h3;
	localparam logic [2:0] DRV_OD_HIGH = 3'h4;
	localparam logic [2:0] DRV_STRONG = 3'h5;
	localparam logic [2:0] DRV_WEAK = 3'h6;
	// Source select
	localparam logic [1:0] SEL_GPIO = 2'h0;
	localparam logic [1:0] SEL_FIX_A = 2'h1;
	localparam logic [1:0] SEL_FIX_B = 2'h2;
	// Interrupt edge select
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [31:0] RST_REG = 32'h0000_0000;

	typedef struct packed {
		logic [4:0][7:0] dout;
		logic [4:0][7:0][2:0] dmode;
		logic [4:0][7:0] in_en;
		logic [4:0][7:0] out_en;
		logic [4:0][7:0] lvttl;
		logic [4:0][7:0] slow;
		logic [4:0][7:0][1:0] alt;
		logic [4:0][7:0] ien;
		logic [4:0][7:0][1:0] iedge;
		logic [4:0][7:0] ista;
		logic [4:0][7:0] pin;
		logic hold;
		logic [31:0] rdata;
		logic [4:0][7:0] pad_out;
		logic [4:0][7:0] pad_oe;
		logic [4:0][7:0] pad_pu;
		logic [4:0][7:0] pad_pd;
		logic [4:0][7:0] pad_ie;
		logic [4:0][7:0] pad_lvttl;
		logic [4:0][7:0] pad_slow;
		logic [4:0][7:0] fa_in;
		logic [4:0][7:0] fb_in;
		logic [4:0] irq;
	} gpb_state_type;
endpackage

// file: core/gpb_port_block.sv
// General-purpose pin block: five 8-bit ports, drive modes, source select, pin interrupts.
// Assumes pad inputs synchronous to core_clk_i and a pad cell that resolves oe/pu/pd.
// Overview of operation
// (R1) Fifteen pins exist; serial and debug pins are usable as general pins.
// (R2) Seven drive modes per pin, from input only to weak/weak.
// (R3) Per-pin threshold select, CMOS or LVTTL.
// (R4) Separate input and output buffer enables on top of the drive mode.
// (R5) Hold freezes each pin's output state and configuration.
// (R6) Per-pin slew-rate select, slow option for noise.
// (R7) Ports of eight bit positions; per-port registers, one bit or field per pin.
// (R8) During reset all pin buffers are disabled.
// (R9) Per-pin select chooses general output or a peripheral as pin source.
// (R10) Peripheral signals reach only their own fixed pin positions.
// (R11) Output-data register drives pins; read-only pin-state register returns levels.
// (R12) Pin raises events only while its interrupt is enabled.
// (R13) One interrupt request line per port, five in all.
// (R14) Hold and pin interrupt detection work on the sleep clock alone; here both run on core_clk_i only.
// (R15) Trigger select: rising, falling or both edges.
// (R16) Pending flag sticks until written one; request high while enabled flag set.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module gpb_port_block
	import gpb_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic [39:0] pad_in_i,
	output logic [39:0] pad_out_o,
	output logic [39:0] pad_oe_o,
	output logic [39:0] pad_pu_o,
	output logic [39:0] pad_pd_o,
	output logic [39:0] pad_ie_o,
	output logic [39:0] pad_lvttl_o,
	output logic [39:0] pad_slow_o,
	input wire logic [39:0] fa_out_i,
	input wire logic [39:0] fa_oe_i,
	input wire logic [39:0] fb_out_i,
	input wire logic [39:0] fb_oe_i,
	output logic [39:0] fa_in_o,
	output logic [39:0] fb_in_o,
	output logic [4:0] irq_o
);

	// Returns {strong drive, weak pull-up, weak pull-down} for a mode and data bit
	function automatic logic [2:0] drive(input logic [2:0] mode, input logic d);
		logic [2:0] r;
		r = 3'h0;
		case (mode)
			DRV_INPUT: r = 3'h0;
			DRV_WUP_SDN: r = {~d, d, 1'b0};
			DRV_SUP_WDN: r = {d, 1'b0, ~d};
			DRV_OD_LOW: r = {~d, 2'b00};
			DRV_OD_HIGH: r = {d, 2'b00};
			DRV_STRONG: r = 3'h4;
			DRV_WEAK: r = {1'b0, d, ~d};
			default: r = 3'h0;
		endcase
		return r;
	endfunction

	gpb_state_type s_q;
	gpb_state_type s_d;
	logic [4:0][7:0] pin_now;
	logic [4:0][7:0] ev;
	logic [4:0][7:0] clr;
	logic [4:0][7:0] present;
	logic [2:0] port_sel;
	logic [3:0] reg_sel;
	logic hit;
	logic d_bit;
	logic oe_req;
	logic [2:0] drv;

	always_comb begin
		s_d = s_q;
		s_d.rdata = RST_REG[31:0];
		present = PIN_PRESENT;
		port_sel = addr_i[6:4];
		reg_sel = addr_i[3:0];
		hit = (addr_i[7] == 1'b0) && (int'(port_sel) < NPORT);
		clr = '0;
		ev = '0;
		d_bit = 1'b0;
		oe_req = 1'b0;
		drv = 3'h0;
		// Disabled input buffer reads low, so no floating level leaks in
		pin_now = pad_in_i & s_q.pad_ie; // (R4)
		s_d.pin = pin_now; // (R11)
		for (int p = 0; p < NPORT; p++) begin
			for (int b = 0; b < NBIT; b++) begin
				case (s_q.iedge[p][b]) // (R15)
					EDGE_RISE: ev[p][b] = pin_now[p][b] & ~s_q.pin[p][b];
					EDGE_FALL: ev[p][b] = ~pin_now[p][b] & s_q.pin[p][b];
					EDGE_BOTH: ev[p][b] = pin_now[p][b] ^ s_q.pin[p][b];
					default: ev[p][b] = 1'b0;
				endcase
			end
		end
		ev = ev & s_q.ien & present; // (R12)
		if (wr_i && hit) begin
			case (reg_sel)
				OFS_DOUT: s_d.dout[port_sel] = wdata_i[7:0] & present[port_sel]; // (R11)
				OFS_DMODE: s_d.dmode[port_sel] = wdata_i[23:0]; // (R2)
				OFS_BUFCFG: begin
					s_d.in_en[port_sel] = wdata_i[BUF_IN_EN_LSB +: 8] & present[port_sel]; // (R4)
					s_d.out_en[port_sel] = wdata_i[BUF_OUT_EN_LSB +: 8] & present[port_sel];
					s_d.lvttl[port_sel] = wdata_i[BUF_LVTTL_LSB +: 8]; // (R3)
					s_d.slow[port_sel] = wdata_i[BUF_SLOW_LSB +: 8]; // (R6)
				end
				OFS_ALTSEL: s_d.alt[port_sel] = wdata_i[15:0]; // (R9)
				OFS_INTEN: s_d.ien[port_sel] = wdata_i[7:0] & present[port_sel];
				OFS_INTEDGE: s_d.iedge[port_sel] = wdata_i[15:0];
				OFS_INTSTAT: clr[port_sel] = wdata_i[7:0];
				OFS_HOLD: s_d.hold = wdata_i[HOLD_BIT]; // (R5)
				default: s_d.hold = s_q.hold;
			endcase
		end
		// New event beats a same-cycle clear
		s_d.ista = (s_q.ista & ~clr) | ev; // (R16)
		if (rd_i && hit) begin
			case (reg_sel)
				OFS_DOUT: s_d.rdata = {24'h00_0000, s_q.dout[port_sel]};
				OFS_PIN: s_d.rdata = {24'h00_0000, s_q.pin[port_sel]}; // (R11)
				OFS_DMODE: s_d.rdata = {8'h00, s_q.dmode[port_sel]};
				OFS_BUFCFG: s_d.rdata = {s_q.slow[port_sel], s_q.lvttl[port_sel],
					s_q.out_en[port_sel], s_q.in_en[port_sel]};
				OFS_ALTSEL: s_d.rdata = {16'h0000, s_q.alt[port_sel]};
				OFS_INTEN: s_d.rdata = {24'h00_0000, s_q.ien[port_sel]};
				OFS_INTEDGE: s_d.rdata = {16'h0000, s_q.iedge[port_sel]};
				OFS_INTSTAT: s_d.rdata = {24'h00_0000, s_q.ista[port_sel]};
				OFS_HOLD: s_d.rdata = {31'h0000_0000, s_q.hold};
				default: s_d.rdata = RST_REG[31:0];
			endcase
		end
		for (int p = 0; p < NPORT; p++) begin
			s_d.irq[p] = |(s_d.ista[p] & s_d.ien[p]); // (R13)
		end
		// Peripheral inputs follow the pin only when that source owns it
		for (int p = 0; p < NPORT; p++) begin
			for (int b = 0; b < NBIT; b++) begin
				s_d.fa_in[p][b] = pin_now[p][b] & (s_q.alt[p][b] == SEL_FIX_A); // (R10)
				s_d.fb_in[p][b] = pin_now[p][b] & (s_q.alt[p][b] == SEL_FIX_B);
			end
		end
		// Pad controls frozen under hold; edge detection above keeps running
		if (!s_q.hold) begin // (R5) (R14)
			for (int p = 0; p < NPORT; p++) begin
				for (int b = 0; b < NBIT; b++) begin
					case (s_q.alt[p][b]) // (R9)
						SEL_FIX_A: begin
							d_bit = fa_out_i[p * NBIT + b];
							oe_req = fa_oe_i[p * NBIT + b];
						end
						SEL_FIX_B: begin
							d_bit = fb_out_i[p * NBIT + b];
							oe_req = fb_oe_i[p * NBIT + b];
						end
						default: begin
							d_bit = s_q.dout[p][b];
							oe_req = 1'b1;
						end
					endcase
					drv = drive(s_q.dmode[p][b], d_bit); // (R2)
					s_d.pad_out[p][b] = d_bit;
					s_d.pad_oe[p][b] = drv[2] & oe_req & s_q.out_en[p][b]; // (R4)
					s_d.pad_pu[p][b] = drv[1] & s_q.out_en[p][b];
					s_d.pad_pd[p][b] = drv[0] & s_q.out_en[p][b];
					s_d.pad_ie[p][b] = s_q.in_en[p][b];
					s_d.pad_lvttl[p][b] = s_q.lvttl[p][b]; // (R3)
					s_d.pad_slow[p][b] = s_q.slow[p][b]; // (R6)
				end
			end
			// Absent positions never drive or load, whatever software writes
			s_d.pad_oe = s_d.pad_oe & present; // (R1) (R7)
			s_d.pad_pu = s_d.pad_pu & present;
			s_d.pad_pd = s_d.pad_pd & present;
			s_d.pad_ie = s_d.pad_ie & present;
		end
	end

	// All-zero reset leaves every buffer disabled
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '0; // (R8)
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_o = s_q.rdata;
	assign pad_out_o = s_q.pad_out;
	assign pad_oe_o = s_q.pad_oe;
	assign pad_pu_o = s_q.pad_pu;
	assign pad_pd_o = s_q.pad_pd;
	assign pad_ie_o = s_q.pad_ie;
	assign pad_lvttl_o = s_q.pad_lvttl;
	assign pad_slow_o = s_q.pad_slow;
	assign fa_in_o = s_q.fa_in;
	assign fb_in_o = s_q.fb_in;
	assign irq_o = s_q.irq;

endmodule
`default_nettype wire
